// File: hdl/pwrctl_low_timer.sv
`timescale 1ns/100ps
// counts milliseconds while a level is held; restarts when it drops
module pwrctl_low_timer
    import pwrctl_pkg::*;
#(
    parameter int LIMIT_MS = 700
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // timebase and level
    input wire logic ms_tick,
    input wire logic active,
    // result
    output logic reached
);
    localparam logic [MS_W-1:0] LIMIT = LIMIT_MS[MS_W-1:0];

    logic [MS_W-1:0] cnt_reg;
    logic [MS_W-1:0] cnt_next;
    logic reached_reg;
    logic reached_next;

    // ---------------------------------------------------------------
    // saturating count; it holds at LIMIT, so the compare uses ==
    // ---------------------------------------------------------------
    always_comb
    begin
        cnt_next = cnt_reg;
        if (!active)
            cnt_next = '0;
        else if (ms_tick && cnt_reg != LIMIT)
            cnt_next = cnt_reg + 14'h0001;
        reached_next = active && (cnt_next == LIMIT);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            reached_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            reached_reg <= reached_next;
        end
    end

    assign reached = reached_reg;

endmodule : pwrctl_low_timer

// File: hdl/pwrctl_pkg.sv
package pwrctl_pkg;

    // ---------------------------------------------------------------
    // timebase
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_US;

    // ---------------------------------------------------------------
    // qualification times, in milliseconds
    // ---------------------------------------------------------------
    localparam int TURN_ON_LOW_TIME_MS = 700;
    localparam int TURN_OFF_LOW_TIME_MS = 1100;
    localparam int MIN_ON_BEFORE_OFF_TIME_MS = 7000;
    localparam int IGN_OFF_LOW_TIME_MS = 500;
    localparam int READY_DELAY_MS = 8000;
    localparam int MS_W = 14;

    // ---------------------------------------------------------------
    // power sequencing, in ticks
    // ---------------------------------------------------------------
    localparam logic [MS_W-1:0] REG_SETTLE_TICKS = 14'h000a;

    // state of the power sequencer, gray coded from off through PWRCTL_REG_DOWN; the step back to off changes two bits
    typedef enum logic [2:0] {
        PWRCTL_OFF = 3'b000,
        PWRCTL_REG_UP = 3'b001,
        PWRCTL_ON = 3'b011,
        PWRCTL_SHUT_REQ = 3'b010,
        PWRCTL_REG_DOWN = 3'b110
    } pwrctl_state_t;

    // supply monitor indications
    typedef struct packed {
        logic supply_low;
        logic supply_over;
    } pwrctl_supply_t;

    // outputs toward the rest of the unit
    typedef struct packed {
        logic reg_en;
        logic unit_rst_n;
        logic shutdown_req;
        logic call_inhibit;
        logic low_batt;
    } pwrctl_ctrl_t;

endpackage : pwrctl_pkg

// File: hdl/pwrctl_top.sv
`timescale 1ns/100ps
// Summary of operation
// - while off, a low on the on/off line held for 700 ms turns the unit on.
// - while on, a low on the on/off line held for 1.1 s starts turning the unit off.
// - an on/off turn-off pulse is ignored until seven seconds have passed since turn-on.
// - the unit turns on and stays on while the ignition input is high, unless supply-low is indicated.
// - ignition turns the unit off only after 500 ms of continuous low.
// - data-set-ready goes low eight seconds after turn-on pulse start or ignition rise.
// - data-set-ready is meaningful only on the uart path, not while usb is selected.
// - a supply-low indication makes the unit shut down through the orderly path.
// - a supply-over indication flags over-voltage and inhibits call setup.
// - an accepted turn-on enables regulators, then releases the unit reset.
// - an accepted turn-off requests processor shutdown and drops regulators after it is done.
// - on/off and ignition are watched at all times, including while off.
module pwrctl_top
    import pwrctl_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int ON_MS = TURN_ON_LOW_TIME_MS,
    parameter int OFF_MS = TURN_OFF_LOW_TIME_MS,
    parameter int MIN_ON_MS = MIN_ON_BEFORE_OFF_TIME_MS,
    parameter int IGN_MS = IGN_OFF_LOW_TIME_MS,
    parameter int DSR_MS = READY_DELAY_MS
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // host control lines
    input wire logic on_off_n,
    input wire logic ignition,
    // supply monitor and path select
    input wire pwrctl_supply_t supply,
    input wire logic usb_sel,
    // main processor handshake
    input wire logic shutdown_done,
    // outputs
    output pwrctl_ctrl_t ctrl,
    output logic dsr_n,
    output logic unit_on
);
    localparam int TICK_W = $clog2(TICK_CYC + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
    localparam logic [MS_W-1:0] MIN_ON = MIN_ON_MS[MS_W-1:0];
    localparam logic [MS_W-1:0] DSR_LIM = DSR_MS[MS_W-1:0];

    // ---------------------------------------------------------------
    // millisecond timebase, always running
    // ---------------------------------------------------------------
    logic [TICK_W-1:0] div_reg;
    logic [TICK_W-1:0] div_next;
    logic tick_reg;
    logic tick_next;

    // divider never stops, so qualification keeps working while off
    always_comb
    begin
        tick_next = (div_reg == TICK_LAST);
        div_next = tick_next ? '0 : div_reg + TICK_W'(1);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // ---------------------------------------------------------------
    // input qualification timers
    // ---------------------------------------------------------------
    logic on_low_ok;
    logic off_low_ok;
    logic ign_low_ok;

    // inputs feed the timers in every state
    pwrctl_low_timer #(.LIMIT_MS(ON_MS)) u_on_tmr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ms_tick(tick_reg),
        .active(!on_off_n),
        .reached(on_low_ok)
    );

    pwrctl_low_timer #(.LIMIT_MS(OFF_MS)) u_off_tmr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ms_tick(tick_reg),
        .active(!on_off_n),
        .reached(off_low_ok)
    );

    pwrctl_low_timer #(.LIMIT_MS(IGN_MS)) u_ign_tmr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ms_tick(tick_reg),
        .active(!ignition),
        .reached(ign_low_ok)
    );

    // ---------------------------------------------------------------
    // power sequencer
    // ---------------------------------------------------------------
    pwrctl_state_t st_reg;
    pwrctl_state_t st_next;
    logic [MS_W-1:0] on_ms_reg;
    logic [MS_W-1:0] on_ms_next;
    logic [MS_W-1:0] seq_reg;
    logic [MS_W-1:0] seq_next;
    logic on_held_reg;
    logic on_held_next;
    logic ign_q_reg;
    logic ign_seen_reg;
    logic ign_seen_next;
    logic dsr_run_reg;
    logic dsr_run_next;
    logic [MS_W-1:0] dsr_ms_reg;
    logic [MS_W-1:0] dsr_ms_next;
    logic dsr_n_reg;
    logic dsr_n_next;
    pwrctl_ctrl_t ctrl_reg;
    pwrctl_ctrl_t ctrl_next;
    logic unit_on_next;
    logic unit_on_reg;
    logic off_ok;

    // turn-off via on/off needs a fresh low after min on-time has elapsed
    assign off_ok = off_low_ok && (on_ms_reg == MIN_ON) && !on_held_reg;

    always_comb
    begin
        st_next = st_reg;
        seq_next = seq_reg;
        on_ms_next = on_ms_reg;
        on_held_next = on_held_reg && !on_off_n;
        ign_seen_next = ign_seen_reg || ignition; // a line never raised cannot turn the unit off
        dsr_run_next = dsr_run_reg;
        dsr_ms_next = dsr_ms_reg;
        ctrl_next = ctrl_reg;
        if (tick_reg && seq_reg != REG_SETTLE_TICKS)
            seq_next = seq_reg + 14'h0001;
        case (st_reg)
            PWRCTL_OFF:
            begin
                // delay starts at pulse start: the held low time counts
                if (!on_off_n && !on_held_reg && !dsr_run_reg)
                begin
                    dsr_run_next = 1'b1;
                    dsr_ms_next = '0;
                end
                else if (on_off_n && !ignition)
                    dsr_run_next = 1'b0;
                if (ignition && !ign_q_reg)
                begin
                    dsr_run_next = 1'b1;
                    dsr_ms_next = '0;
                end
                // a low still held from the turn-off must be released before it counts again
                if ((on_low_ok && !on_held_reg) || ignition)
                begin
                    st_next = PWRCTL_REG_UP;
                    seq_next = '0;
                    ctrl_next.reg_en = 1'b1;
                    on_held_next = !on_off_n;
                end
            end
            PWRCTL_REG_UP:
            begin
                if (seq_reg == REG_SETTLE_TICKS)
                begin
                    ctrl_next.unit_rst_n = 1'b1;
                    st_next = PWRCTL_ON;
                    on_ms_next = '0;
                end
            end
            PWRCTL_ON:
            begin
                if (tick_reg && on_ms_reg != MIN_ON)
                    on_ms_next = on_ms_reg + 14'h0001;
                if (ignition && !ign_q_reg)
                begin
                    dsr_run_next = 1'b1;
                    dsr_ms_next = '0;
                end
                // ignition high keeps the unit on; low battery still wins
                if (supply.supply_low || (!ignition && (off_ok || (ign_low_ok && ign_seen_reg))))
                begin
                    st_next = PWRCTL_SHUT_REQ;
                    on_held_next = !on_off_n;
                    ctrl_next.shutdown_req = 1'b1;
                end
            end
            PWRCTL_SHUT_REQ:
            begin
                if (shutdown_done)
                begin
                    ctrl_next.shutdown_req = 1'b0;
                    ctrl_next.unit_rst_n = 1'b0;
                    st_next = PWRCTL_REG_DOWN;
                    dsr_run_next = 1'b0;
                end
            end
            PWRCTL_REG_DOWN:
            begin
                ctrl_next.reg_en = 1'b0;
                ign_seen_next = 1'b0;
                st_next = PWRCTL_OFF;
            end
            default:
            begin
                st_next = PWRCTL_OFF;
                ctrl_next = '0;
            end
        endcase
        if (dsr_run_next && tick_reg && dsr_ms_reg != DSR_LIM)
            dsr_ms_next = dsr_ms_next + 14'h0001;
        // uart path only; usb selected keeps the line idle high
        dsr_n_next = !(dsr_run_next && dsr_ms_next == DSR_LIM && st_next == PWRCTL_ON
                       && !usb_sel);
        ctrl_next.call_inhibit = supply.supply_over;
        ctrl_next.low_batt = supply.supply_low;
        unit_on_next = (st_next == PWRCTL_ON);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_reg <= PWRCTL_OFF;
            seq_reg <= '0;
            on_ms_reg <= '0;
            on_held_reg <= 1'b0;
            ign_q_reg <= 1'b0;
            ign_seen_reg <= 1'b0;
            dsr_run_reg <= 1'b0;
            dsr_ms_reg <= '0;
            dsr_n_reg <= 1'b1;
            ctrl_reg <= '0;
            unit_on_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            seq_reg <= seq_next;
            on_ms_reg <= on_ms_next;
            on_held_reg <= on_held_next;
            ign_q_reg <= ignition;
            ign_seen_reg <= ign_seen_next;
            dsr_run_reg <= dsr_run_next;
            dsr_ms_reg <= dsr_ms_next;
            dsr_n_reg <= dsr_n_next;
            ctrl_reg <= ctrl_next;
            unit_on_reg <= unit_on_next;
        end
    end

    assign ctrl = ctrl_reg;
    assign dsr_n = dsr_n_reg;
    assign unit_on = unit_on_reg;

endmodule : pwrctl_top

// File: test/power_on_off_control_tb.sv
`timescale 1ns/100ps
module power_on_off_control_tb;
    import pwrctl_pkg::*;
    // ---------------------------------------------------------------
    // shortened timing: one ms is T cycles
    // ---------------------------------------------------------------
    localparam int T = 10;
    localparam int ON = 7;
    localparam int OFF = 11;
    localparam int MIN = 70;
    localparam int IGN = 5;
    localparam int DSR = 80;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic on_off_n = 1'b1;
    logic ignition = 1'b0;
    pwrctl_supply_t supply = '0;
    logic usb_sel = 1'b0;
    logic slow = 1'b0;
    logic shutdown_done;
    pwrctl_ctrl_t ctrl;
    logic dsr_n;
    logic unit_on;
    logic send_ok;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0;
    int t_p;
    int t_on;

    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    pwrctl_top #(.TICK_CYC(T), .ON_MS(ON), .OFF_MS(OFF), .MIN_ON_MS(MIN), .IGN_MS(IGN),
        .DSR_MS(DSR)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .on_off_n(on_off_n),
        .ignition(ignition), .supply(supply), .usb_sel(usb_sel),
        .shutdown_done(shutdown_done), .ctrl(ctrl), .dsr_n(dsr_n), .unit_on(unit_on));
    pwrctl_host_model i_host (.sys_clk(sys_clk), .shutdown_req(ctrl.shutdown_req),
        .slow(slow), .shutdown_done(shutdown_done), .dsr_n(dsr_n), .send_ok(send_ok));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task summarize;
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    function logic pick(input int s);
        case (s)
            0: return ctrl.reg_en;
            2: return ctrl.shutdown_req;
            3: return dsr_n;
            default: return unit_on;
        endcase
    endfunction : pick

    // waits for a level, then judges its delay from t0; a lapsed bound ends the run
    task wait_sig(input string nm, input int s, input logic v, input int lo, input int hi);
        while (pick(s) !== v && cyc - t0 <= hi)
            @(negedge sys_clk);
        if (pick(s) !== v)
        begin
            check(nm, 16'h0000, 16'h0001);
            summarize();
        end
        else
            check(nm, 16'(cyc - t0 >= lo), 16'h0001);
    endtask : wait_sig

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_press_on;
        on_off_n = 1'b0;
        repeat ((ON - 2) * T) @(negedge sys_clk);
        on_off_n = 1'b1;
        repeat (3 * T) @(negedge sys_clk);
        check("reg_en short", 16'(ctrl.reg_en), 16'h0000);
        on_off_n = 1'b0;
        t0 = cyc;
        t_p = cyc;
        wait_sig("reg_en press", 0, 1'b1, (ON - 1) * T, (ON + 1) * T + 4);
        check("unit_rst_n early", 16'(ctrl.unit_rst_n), 16'h0000);
        repeat (2 * T) @(negedge sys_clk);
        on_off_n = 1'b1;
        wait_sig("unit_on", 4, 1'b1, (ON + 9) * T, (ON + 12) * T + 4);
        t_on = cyc;
        check("unit_rst_n", 16'(ctrl.unit_rst_n), 16'h0001);
        check("send_ok early", 16'(send_ok), 16'h0000);
    endtask : t_press_on

    // an early press is ignored, a later one goes through the orderly path
    task t_press_off;
        on_off_n = 1'b0;
        repeat ((OFF + 2) * T) @(negedge sys_clk);
        on_off_n = 1'b1;
        check("unit_on early off", 16'(unit_on), 16'h0001);
        t0 = t_p;
        wait_sig("dsr_n press", 3, 1'b0, (DSR - 1) * T, (DSR + 1) * T + 4);
        usb_sel = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("dsr_n usb", 16'(dsr_n), 16'h0001);
        usb_sel = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("dsr_n uart", 16'(dsr_n), 16'h0000);
        check("send_ok", 16'(send_ok), 16'h0001);
        while (cyc - t_on < (MIN + 2) * T)
            @(negedge sys_clk);
        on_off_n = 1'b0;
        t0 = cyc;
        wait_sig("shutdown_req", 2, 1'b1, (OFF - 1) * T, (OFF + 1) * T + 4);
        check("reg_en in shutdown", 16'(ctrl.reg_en), 16'h0001);
        repeat (2 * T) @(negedge sys_clk);
        on_off_n = 1'b1;
        check("reg_en off", 16'(ctrl.reg_en), 16'h0000);
        check("dsr_n off", 16'(dsr_n), 16'h0001);
    endtask : t_press_off

    // ignition on, bounce ignored, over-voltage, slow processor shutdown
    task t_ignition;
        ignition = 1'b1;
        t0 = cyc;
        wait_sig("reg_en ign", 0, 1'b1, 1, 4);
        wait_sig("dsr_n ign", 3, 1'b0, (DSR - 1) * T, (DSR + 1) * T + 4);
        ignition = 1'b0;
        repeat ((IGN - 2) * T) @(negedge sys_clk);
        ignition = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("unit_on bounce", 16'(unit_on), 16'h0001);
        supply.supply_over = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("call_inhibit", 16'(ctrl.call_inhibit), 16'h0001);
        supply.supply_over = 1'b0;
        slow = 1'b1;
        ignition = 1'b0;
        t0 = cyc;
        wait_sig("shutdown_req ign", 2, 1'b1, (IGN - 1) * T, (IGN + 1) * T + 4);
        repeat (100) @(negedge sys_clk);
        check("reg_en slow", 16'(ctrl.reg_en), 16'h0001);
        t0 = cyc;
        wait_sig("shutdown_req end", 2, 1'b0, 150, 260);
        slow = 1'b0;
    endtask : t_ignition

    task t_supply_low;
        ignition = 1'b1;
        t0 = cyc;
        wait_sig("unit_on ign", 4, 1'b1, 9 * T, 12 * T + 4);
        supply.supply_low = 1'b1;
        t0 = cyc;
        wait_sig("shutdown_req low", 2, 1'b1, 1, 4);
        check("low_batt", 16'(ctrl.low_batt), 16'h0001);
        ignition = 1'b0;
        t0 = cyc;
        wait_sig("reg_en low", 0, 1'b0, 0, 10);
        supply.supply_low = 1'b0;
    endtask : t_supply_low

    initial
    begin
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        t_press_on();
        t_press_off();
        t_ignition();
        t_supply_low();
        summarize();
    end
endmodule : power_on_off_control_tb

// File: test/pwrctl_chk.sv
`timescale 1ns/100ps
// watches the sequencer ports; bound into every top instance
module pwrctl_chk
    import pwrctl_pkg::*;
#(
    parameter int TICK_CYC = 10,
    parameter int ON_MS = 7,
    parameter int MIN_ON_MS = 70
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // inputs
    input wire logic on_off_n,
    input wire logic ignition,
    input wire pwrctl_supply_t supply,
    input wire logic shutdown_done,
    // outputs
    input wire pwrctl_ctrl_t ctrl,
    input wire logic dsr_n,
    input wire logic unit_on
);
    // ---------------------------------------------------------------
    // helper counters
    // ---------------------------------------------------------------
    logic [15:0] low_reg;
    logic [15:0] on_reg;
    // saturating, so a very long press cannot wrap under the limit
    always_ff @(posedge sys_clk)
    begin
        low_reg <= (!rst_n || on_off_n) ? 16'h0000 : low_reg + {15'h0000, ~&low_reg};
        on_reg <= (!rst_n || !unit_on) ? 16'h0000 : on_reg + {15'h0000, ~&on_reg};
    end

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_over_inhibits_call: assert property ($rose(supply.supply_over) |=> ctrl.call_inhibit)
        else $error("call inhibit missing after supply over");
    a_low_supply_off: assert property ($rose(supply.supply_low) && unit_on |-> ##[1:3] ctrl.shutdown_req)
        else $error("no shutdown request after supply low");
    a_dsr_only_on: assert property (!dsr_n |-> unit_on)
        else $error("data set ready low while not on");
    a_reg_before_release: assert property (ctrl.unit_rst_n |-> ctrl.reg_en)
        else $error("unit reset released without regulators");
    a_release_after_settle: assert property ($rose(ctrl.reg_en) |-> !ctrl.unit_rst_n [*8])
        else $error("unit reset released too early");
    a_drop_after_done: assert property ($fell(ctrl.reg_en) |->
        $past(ctrl.shutdown_req, 2) && $past(shutdown_done, 2))
        else $error("regulators dropped without finished shutdown");
    a_press_long_on: assert property ($rose(ctrl.reg_en) && !ignition |->
        low_reg >= (ON_MS - 1) * TICK_CYC)
        else $error("turn on after too short a press");
    a_min_on_off: assert property ($rose(ctrl.shutdown_req) && !on_off_n |->
        on_reg >= MIN_ON_MS * TICK_CYC)
        else $error("turn off press accepted too soon");
    a_ign_turns_on: assert property ($rose(ignition) && !ctrl.reg_en |-> ##[1:3] ctrl.reg_en)
        else $error("ignition did not turn the unit on");

    c_press_on: cover property ($rose(ctrl.reg_en) && !ignition);
    c_ign_off: cover property ($rose(ctrl.shutdown_req) && on_off_n);
    c_dsr_low: cover property ($fell(dsr_n));
endmodule : pwrctl_chk

bind pwrctl_top pwrctl_chk #(.TICK_CYC(TICK_CYC), .ON_MS(ON_MS), .MIN_ON_MS(MIN_ON_MS)) i_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .on_off_n(on_off_n), .ignition(ignition),
    .supply(supply), .shutdown_done(shutdown_done), .ctrl(ctrl), .dsr_n(dsr_n),
    .unit_on(unit_on));

// File: test/pwrctl_host_model.sv
`timescale 1ns/100ps
// processor side of the shutdown handshake and the host send gate
module pwrctl_host_model
(
    // clock
    input wire logic sys_clk,
    // shutdown handshake
    input wire logic shutdown_req,
    input wire logic slow,
    output logic shutdown_done,
    // host send gate
    input wire logic dsr_n,
    output logic send_ok
);
    int cnt = 0;
    initial shutdown_done = 1'b0;
    // done is held until the request drops, as firmware would leave it
    always @(posedge sys_clk)
    begin
        cnt <= shutdown_req ? cnt + 1 : 0;
        shutdown_done <= shutdown_req && (cnt >= (slow ? 300 : 2));
    end
    // nothing is sent before data set ready is seen low
    assign send_ok = !dsr_n;
endmodule : pwrctl_host_model
